//--- core/tlx_defines.svh
// constants for the trigger line crossbar: map, fields, timing
// assumes inclusion by the package and the design modules only
`ifndef TLX_DEFINES_SVH
`define TLX_DEFINES_SVH
`define TLX_N_FRONT 3
`define TLX_N_SHARED 8
`define TLX_N_STAR 13
`define TLX_N_EVENT 4
`define TLX_N_DEST 24
`define TLX_SEL_W 5
`define TLX_SRC_W 32
`define TLX_SRC_FRONT 0
`define TLX_SRC_SHARED 3
`define TLX_SRC_STAR 11
`define TLX_SRC_EVENT 24
`define TLX_SRC_REF 28
`define TLX_SRC_GND 29
`define TLX_DEST_SHARED 3
`define TLX_DEST_STAR 11
`define TLX_CFG_W 11
`define TLX_CFG_SEL_LSB 0
`define TLX_CFG_EN 8
`define TLX_CFG_SYNC 9
`define TLX_CFG_INV 10
`define TLX_ADDR_W 8
`define TLX_ROUTE_BASE 8'h00
`define TLX_ROUTE_LAST 8'h5C
`define TLX_TS_CTRL 8'h60
`define TLX_STATUS 8'h64
`define TLX_SCHED 8'h68
`define TLX_ST_CLOSED 0
`define TLX_ST_SETTLE 1
`define TLX_ST_LVL 2
`define TLX_ST_REF 5
`define TLX_CLK_MHZ 40
`define TLX_SETTLE_MS 5
`define TLX_SETTLE_CYC (`TLX_SETTLE_MS * 1000 * `TLX_CLK_MHZ)
`define TLX_DRAIN_US 1
`define TLX_DRAIN_CYC (`TLX_DRAIN_US * `TLX_CLK_MHZ)
`define TLX_CNT_W 20
`endif

//--- core/tlx_pkg.sv
// types and shared decode helpers for the trigger line crossbar
// assumes tlx_defines.svh is on the include path
package tlx_pkg;
    `include "tlx_defines.svh"

    typedef enum logic [2:0] {
        TLX_RLY_OPEN,
        TLX_RLY_CLOSING,
        TLX_RLY_CLOSED,
        TLX_RLY_DRAIN,
        TLX_RLY_OPENING
    } tlx_relay_state_t;

    typedef logic [`TLX_SEL_W-1:0] tlx_sel_t;

    function automatic logic tlx_is_event(input tlx_sel_t sel);
        return (sel >= tlx_sel_t'(`TLX_SRC_EVENT)) && (sel < tlx_sel_t'(`TLX_SRC_REF));
    endfunction : tlx_is_event
endpackage : tlx_pkg

//--- core/tlx_route_cell.sv
// one destination line of the crossbar: source pick, polarity, realign
// assumes sources and the reference-edge pulse are already on mclk_i
`timescale 1ns/1ps
`include "tlx_defines.svh"
module tlx_route_cell (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [`TLX_SRC_W-1:0] src_i,
    input wire tlx_pkg::tlx_sel_t sel_i,
    input wire logic enable_i,
    input wire logic sync_i,
    input wire logic invert_i,
    input wire logic ref_rise_i,
    input wire logic force_low_i,
    input wire logic hold_oe_i,
    output logic line_o,
    output logic line_oe_o
);
    import tlx_pkg::*;

    logic picked;
    logic is_evt;

    assign picked = src_i[sel_i] ^ invert_i;
    assign is_evt = tlx_is_event(sel_i);

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            line_o <= 1'b0;
        end else if (force_low_i) begin
            line_o <= 1'b0;
        end else if (!sync_i || is_evt) begin
            line_o <= picked;
        end else if (ref_rise_i) begin
            line_o <= picked;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            line_oe_o <= 1'b0;
        end else begin
            line_oe_o <= enable_i || hold_oe_i;
        end
    end

    property p_event_unsync;
        @(posedge mclk_i) disable iff (rst_i)
        (is_evt && !force_low_i) |=> (line_o == $past(picked));
    endproperty
    a_event_unsync: assert property (p_event_unsync) else $error("event source was held for realignment");

    property p_sync_waits;
        @(posedge mclk_i) disable iff (rst_i)
        (sync_i && !is_evt && !force_low_i && !ref_rise_i) |=> $stable(line_o);
    endproperty
    a_sync_waits: assert property (p_sync_waits) else $error("realigned output moved off a reference edge");

    property p_async_follow;
        @(posedge mclk_i) disable iff (rst_i)
        (!sync_i && !force_low_i) |=> (line_o == $past(picked));
    endproperty
    a_async_follow: assert property (p_async_follow) else $error("output does not follow its selected source");

    property p_oe_off;
        @(posedge mclk_i) disable iff (rst_i)
        (!enable_i && !hold_oe_i) |=> !line_oe_o;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("disabled line still driven");
endmodule : tlx_route_cell

//--- core/tlx_relay_ctrl.sv
// isolation relay sequencer for the dual-use front line
// assumes want_i and restart_i come from logic on mclk_i
`timescale 1ns/1ps
`include "tlx_defines.svh"
module tlx_relay_ctrl #(
    parameter int SETTLE_CYCLES = `TLX_SETTLE_CYC
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic want_i,
    input wire logic restart_i,
    output logic close_o,
    output logic settle_o,
    output logic drive_low_o,
    output logic keep_oe_o
);
    import tlx_pkg::*;

    tlx_relay_state_t state;
    logic [`TLX_CNT_W-1:0] cnt;
    logic done;

    assign done = (cnt == '0);
    // the relay itself is slow, so the line is untrusted in every state but closed
    assign settle_o = (state != TLX_RLY_CLOSED);
    assign drive_low_o = (state == TLX_RLY_CLOSING) || (state == TLX_RLY_DRAIN) || (state == TLX_RLY_OPENING);
    assign keep_oe_o = (state == TLX_RLY_DRAIN);

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state <= TLX_RLY_OPEN;
            cnt <= '0;
        end else begin
            case (state)
                TLX_RLY_OPEN: begin
                    if (want_i) begin
                        state <= TLX_RLY_CLOSING;
                        cnt <= `TLX_CNT_W'(SETTLE_CYCLES - 1);
                    end
                end
                TLX_RLY_CLOSING: begin
                    if (!want_i) begin
                        state <= TLX_RLY_OPENING;
                        cnt <= `TLX_CNT_W'(SETTLE_CYCLES - 1);
                    end else if (restart_i) begin
                        cnt <= `TLX_CNT_W'(SETTLE_CYCLES - 1);
                    end else if (done) begin
                        state <= TLX_RLY_CLOSED;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                TLX_RLY_CLOSED: begin
                    if (!want_i) begin
                        state <= TLX_RLY_DRAIN;
                        cnt <= `TLX_CNT_W'(`TLX_DRAIN_CYC - 1);
                    end else if (restart_i) begin
                        state <= TLX_RLY_CLOSING;
                        cnt <= `TLX_CNT_W'(SETTLE_CYCLES - 1);
                    end
                end
                TLX_RLY_DRAIN: begin
                    if (done) begin
                        state <= TLX_RLY_OPENING;
                        cnt <= `TLX_CNT_W'(SETTLE_CYCLES - 1);
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                TLX_RLY_OPENING: begin
                    if (done) begin
                        state <= TLX_RLY_OPEN;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                default: begin
                    state <= TLX_RLY_OPEN;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            close_o <= 1'b0;
        end else begin
            close_o <= (state == TLX_RLY_CLOSING) || (state == TLX_RLY_CLOSED) || (state == TLX_RLY_DRAIN);
        end
    end

    property p_close_cause;
        @(posedge mclk_i) disable iff (rst_i)
        $rose(close_o) |-> $past(want_i, 2);
    endproperty
    a_close_cause: assert property (p_close_cause) else $error("relay closed with no digital use");

    property p_close_settle;
        @(posedge mclk_i) disable iff (rst_i)
        $rose(close_o) |-> (settle_o && drive_low_o) [*8];
    endproperty
    a_close_settle: assert property (p_close_settle) else $error("line not held low while relay closes");

    property p_drain_first;
        @(posedge mclk_i) disable iff (rst_i)
        $fell(close_o) |-> (($past(keep_oe_o, 2) || $past(state == TLX_RLY_CLOSING, 2)) && $past(drive_low_o, 2));
    endproperty
    a_drain_first: assert property (p_drain_first) else $error("relay opened without driving low first");

    property p_open_settle;
        @(posedge mclk_i) disable iff (rst_i)
        $fell(close_o) |-> settle_o [*8];
    endproperty
    a_open_settle: assert property (p_open_settle) else $error("opening relay not treated as settling");
endmodule : tlx_relay_ctrl

//--- core/tlx_crossbar.sv
// trigger line crossbar top: apb registers, pin synchronisers, 24 routes,
// front-line edge timestamp strobes and the dual-use line relay
// assumes an apb master on mclk_i and pins asynchronous to mclk_i
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "tlx_defines.svh"
module tlx_crossbar #(
    parameter int SETTLE_CYCLES = `TLX_SETTLE_CYC
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [`TLX_ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [`TLX_N_FRONT-1:0] front_panel_line_i,
    output logic [`TLX_N_FRONT-1:0] front_panel_line_o,
    output logic [`TLX_N_FRONT-1:0] front_panel_line_oe_o,
    input wire logic [`TLX_N_SHARED-1:0] shared_trigger_line_i,
    output logic [`TLX_N_SHARED-1:0] shared_trigger_line_o,
    output logic [`TLX_N_SHARED-1:0] shared_trigger_line_oe_o,
    input wire logic [`TLX_N_STAR-1:0] star_trigger_line_i,
    output logic [`TLX_N_STAR-1:0] star_trigger_line_o,
    output logic [`TLX_N_STAR-1:0] star_trigger_line_oe_o,
    input wire logic backplane_ref_clock_i,
    input wire logic [`TLX_N_EVENT-1:0] time_event_i,
    output logic isolation_relay_close_o,
    output logic [`TLX_N_FRONT-1:0] timestamp_strobe_o,
    output logic [`TLX_N_FRONT-1:0] timestamp_rising_o
);
    import tlx_pkg::*;

    localparam int N_PIN = `TLX_N_FRONT + `TLX_N_SHARED + `TLX_N_STAR;

    logic [`TLX_CFG_W-1:0] route_cfg [0:`TLX_N_DEST-1];
    logic [2*`TLX_N_FRONT-1:0] ts_ctrl;
    logic sched_dual;

    logic [N_PIN-1:0] pin_s1;
    logic [N_PIN-1:0] pin_s2;
    logic [N_PIN-1:0] pin_s3;
    logic [N_PIN-1:0] pin_lvl;
    logic ref_s1;
    logic ref_s2;
    logic ref_s3;
    logic ref_lvl;
    logic ref_rise;

    logic [`TLX_N_FRONT-1:0] front_prev;
    logic [`TLX_SRC_W-1:0] src_vec;
    logic [`TLX_N_DEST-1:0] dest_line;
    logic [`TLX_N_DEST-1:0] dest_oe;

    logic dual_want;
    logic dual_restart;
    logic relay_settle;
    logic relay_low;
    logic relay_keep_oe;

    logic setup_ph;
    logic access_ph;
    logic wr_go;
    logic addr_ok;
    logic [31:0] rd_word;
    logic [`TLX_ADDR_W-3:0] word_idx;

    function automatic logic route_hits_dual(input logic [`TLX_CFG_W-1:0] cfg, input int dest);
        return cfg[`TLX_CFG_EN] &&
            ((dest == 0) || (cfg[`TLX_CFG_SEL_LSB +: `TLX_SEL_W] == tlx_sel_t'(`TLX_SRC_FRONT)));
    endfunction : route_hits_dual

    function automatic logic is_route_addr(input logic [`TLX_ADDR_W-1:0] a);
        return (a >= `TLX_ROUTE_BASE) && (a <= `TLX_ROUTE_LAST);
    endfunction : is_route_addr

    // apb slave: zero wait states, read data captured in the setup cycle
    assign setup_ph = psel_i && !penable_i;
    assign access_ph = psel_i && penable_i;
    assign pready_o = 1'b1;
    assign wr_go = access_ph && pwrite_i && addr_ok;
    assign word_idx = paddr_i[`TLX_ADDR_W-1:2];

    always_comb begin
        addr_ok = 1'b0;
        rd_word = 32'h0000_0000;
        if (paddr_i[1:0] != 2'b00) begin
            addr_ok = 1'b0;
        end else if (is_route_addr(paddr_i)) begin
            addr_ok = 1'b1;
            rd_word[`TLX_CFG_W-1:0] = route_cfg[word_idx[4:0]];
        end else if (paddr_i == `TLX_TS_CTRL) begin
            addr_ok = 1'b1;
            rd_word[2*`TLX_N_FRONT-1:0] = ts_ctrl;
        end else if (paddr_i == `TLX_STATUS) begin
            addr_ok = !pwrite_i;
            rd_word[`TLX_ST_CLOSED] = isolation_relay_close_o;
            rd_word[`TLX_ST_SETTLE] = relay_settle;
            rd_word[`TLX_ST_LVL +: `TLX_N_FRONT] = pin_lvl[`TLX_N_FRONT-1:0];
            rd_word[`TLX_ST_REF] = ref_lvl;
        end else if (paddr_i == `TLX_SCHED) begin
            addr_ok = 1'b1;
            rd_word[0] = sched_dual;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (setup_ph && !pwrite_i) begin
            prdata_o <= rd_word;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pslverr_o <= 1'b0;
        end else begin
            pslverr_o <= setup_ph && !addr_ok;
        end
    end

    // every line resets as an undriven input routed from ground
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            for (int i = 0; i < `TLX_N_DEST; i++) begin
                route_cfg[i] <= `TLX_CFG_W'(`TLX_SRC_GND);
            end
        end else if (wr_go && is_route_addr(paddr_i)) begin
            route_cfg[word_idx[4:0]] <= pwdata_i[`TLX_CFG_W-1:0];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ts_ctrl <= '0;
        end else if (wr_go && (paddr_i == `TLX_TS_CTRL)) begin
            ts_ctrl <= pwdata_i[2*`TLX_N_FRONT-1:0];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            sched_dual <= 1'b0;
        end else if (wr_go && (paddr_i == `TLX_SCHED)) begin
            sched_dual <= pwdata_i[0];
        end
    end

    // a write that adds, removes or retargets a route on the dual-use line
    always_comb begin
        dual_restart = 1'b0;
        if (wr_go && is_route_addr(paddr_i)) begin
            dual_restart = route_hits_dual(route_cfg[word_idx[4:0]], int'(word_idx[4:0])) ||
                route_hits_dual(pwdata_i[`TLX_CFG_W-1:0], int'(word_idx[4:0]));
        end
    end

    always_comb begin
        dual_want = sched_dual || (ts_ctrl[1:0] != 2'b00);
        for (int d = 0; d < `TLX_N_DEST; d++) begin
            if (route_hits_dual(route_cfg[d], d)) begin
                dual_want = 1'b1;
            end
        end
    end

    // three-stage pin synchronisers, a level is accepted when the second and third stages agree
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            pin_s3 <= '0;
        end else begin
            pin_s1 <= {star_trigger_line_i, shared_trigger_line_i, front_panel_line_i};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pin_lvl <= '0;
        end else begin
            for (int i = 0; i < N_PIN; i++) begin
                if (pin_s2[i] == pin_s3[i]) begin
                    pin_lvl[i] <= pin_s3[i];
                end
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ref_s1 <= 1'b0;
            ref_s2 <= 1'b0;
            ref_s3 <= 1'b0;
            ref_lvl <= 1'b0;
        end else begin
            ref_s1 <= backplane_ref_clock_i;
            ref_s2 <= ref_s1;
            ref_s3 <= ref_s2;
            if (ref_s2 == ref_s3) begin
                ref_lvl <= ref_s3;
            end
        end
    end

    // only the backplane reference can realign, there is no clock select
    assign ref_rise = (ref_s2 == ref_s3) && ref_s3 && !ref_lvl;

    // source order: front, shared, star, events, reference, ground
    always_comb begin
        src_vec = '0;
        src_vec[`TLX_SRC_FRONT +: `TLX_N_FRONT] = pin_lvl[`TLX_N_FRONT-1:0];
        src_vec[`TLX_SRC_FRONT] = pin_lvl[0] && !relay_settle;
        src_vec[`TLX_SRC_SHARED +: `TLX_N_SHARED] = pin_lvl[`TLX_N_FRONT +: `TLX_N_SHARED];
        src_vec[`TLX_SRC_STAR +: `TLX_N_STAR] = pin_lvl[`TLX_N_FRONT + `TLX_N_SHARED +: `TLX_N_STAR];
        src_vec[`TLX_SRC_EVENT +: `TLX_N_EVENT] = time_event_i;
        src_vec[`TLX_SRC_REF] = ref_lvl;
        src_vec[`TLX_SRC_GND] = 1'b0;
    end

    // one cell per destination: front 0..2, shared 3..10, star 11..23
    for (genvar d = 0; d < `TLX_N_DEST; d++) begin : g_dest
        tlx_route_cell u_cell (
            .mclk_i(mclk_i),
            .rst_i(rst_i),
            .src_i(src_vec),
            .sel_i(route_cfg[d][`TLX_CFG_SEL_LSB +: `TLX_SEL_W]),
            .enable_i(route_cfg[d][`TLX_CFG_EN]),
            .sync_i(route_cfg[d][`TLX_CFG_SYNC]),
            .invert_i(route_cfg[d][`TLX_CFG_INV]),
            .ref_rise_i(ref_rise),
            .force_low_i((d == 0) && relay_low),
            .hold_oe_i((d == 0) && relay_keep_oe),
            .line_o(dest_line[d]),
            .line_oe_o(dest_oe[d])
        );
    end

    assign front_panel_line_o = dest_line[`TLX_N_FRONT-1:0];
    assign front_panel_line_oe_o = dest_oe[`TLX_N_FRONT-1:0];
    assign shared_trigger_line_o = dest_line[`TLX_DEST_SHARED +: `TLX_N_SHARED];
    assign shared_trigger_line_oe_o = dest_oe[`TLX_DEST_SHARED +: `TLX_N_SHARED];
    assign star_trigger_line_o = dest_line[`TLX_DEST_STAR +: `TLX_N_STAR];
    assign star_trigger_line_oe_o = dest_oe[`TLX_DEST_STAR +: `TLX_N_STAR];

    tlx_relay_ctrl #(
        .SETTLE_CYCLES(SETTLE_CYCLES)
    ) u_relay (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .want_i(dual_want),
        .restart_i(dual_restart),
        .close_o(isolation_relay_close_o),
        .settle_o(relay_settle),
        .drive_low_o(relay_low),
        .keep_oe_o(relay_keep_oe)
    );

    // edge strobes for the time base; a driven line still reports its edges
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            front_prev <= '0;
        end else begin
            front_prev <= pin_lvl[`TLX_N_FRONT-1:0];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            timestamp_strobe_o <= '0;
            timestamp_rising_o <= '0;
        end else begin
            for (int i = 0; i < `TLX_N_FRONT; i++) begin
                timestamp_rising_o[i] <= pin_lvl[i];
                timestamp_strobe_o[i] <= (pin_lvl[i] && !front_prev[i] && ts_ctrl[2*i]) ||
                    (!pin_lvl[i] && front_prev[i] && ts_ctrl[2*i+1]);
            end
            // edges seen while the relay is open or moving are not trusted, so they are dropped
            if (relay_settle) begin
                timestamp_strobe_o[0] <= 1'b0;
            end
        end
    end

    property p_ts_quiet;
        @(posedge mclk_i) disable iff (rst_i)
        timestamp_strobe_o[0] |-> !$past(relay_settle);
    endproperty
    a_ts_quiet: assert property (p_ts_quiet) else $error("dual-use timestamp while relay settles");

    property p_ts_edge;
        @(posedge mclk_i) disable iff (rst_i)
        (timestamp_strobe_o[2] && timestamp_rising_o[2]) |-> $past(ts_ctrl[4]);
    endproperty
    a_ts_edge: assert property (p_ts_edge) else $error("rising strobe without rising edge enabled");

    property p_restart_settle;
        @(posedge mclk_i) disable iff (rst_i)
        (dual_restart && dual_want && isolation_relay_close_o) |=> ##1 relay_settle [*4];
    endproperty
    a_restart_settle: assert property (p_restart_settle) else $error("dual-use route change without settle");

    // losing use while closed drains first, so the open comes after the drain
    localparam int OPEN_WAIT = `TLX_DRAIN_CYC + 3;

    property p_relay_want;
        @(posedge mclk_i) disable iff (rst_i)
        (!dual_want && !relay_settle) |-> ##[1:OPEN_WAIT] !isolation_relay_close_o;
    endproperty
    a_relay_want: assert property (p_relay_want) else $error("relay closed with no digital use");

    property p_bad_addr;
        @(posedge mclk_i) disable iff (rst_i)
        (setup_ph && !addr_ok) |=> (pslverr_o && access_ph) or !access_ph;
    endproperty
    a_bad_addr: assert property (p_bad_addr) else $error("unmapped access not flagged");

    property p_sync_ref;
        @(posedge mclk_i) disable iff (rst_i)
        $changed(shared_trigger_line_o[0]) && $past(route_cfg[`TLX_DEST_SHARED][`TLX_CFG_SYNC]) &&
            !$past(tlx_is_event(route_cfg[`TLX_DEST_SHARED][`TLX_CFG_SEL_LSB +: `TLX_SEL_W])) |->
            $past(ref_rise);
    endproperty
    a_sync_ref: assert property (p_sync_ref) else $error("realigned shared line moved off reference");
endmodule : tlx_crossbar

//--- tb/tlx_far_model.sv
// far side: other modules and cabled equipment on the crossbar pins
// assumes the bench gives the levels that the far side wants to drive
`timescale 1ns/1ps
module tlx_far_model (
    input wire logic mclk_i,
    input wire logic [23:0] lvl_i,
    input wire logic [23:0] dev_i,
    input wire logic [23:0] oe_i,
    output logic [23:0] pin_o,
    output logic ref_o
);
    logic [1:0] div = 2'h0;
    // a line that the crossbar drives is only received here
    assign pin_o = (oe_i & dev_i) | (~oe_i & lvl_i);
    assign ref_o = div[1];
    always_ff @(posedge mclk_i) begin
        div <= div + 2'h1;
    end
endmodule : tlx_far_model

//--- tb/test_tlx_crossbar.sv
// self-checking bench for the trigger line crossbar
// assumes the far model closes the pin loop and makes the reference
`timescale 1ns/1ps
module test_tlx_crossbar;
    logic mclk, rst, psel, penable, pwrite, pready, pslverr, refclk, relay, e;
    logic [7:0] nstb = 8'h00;
    logic [7:0] k;
    logic [2:0] tsr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [23:0] lvl, pin, dout, doe;
    logic [3:0] tev;
    logic [2:0] tss;
    int mismatches, tests_run, cyc;
    tlx_crossbar #(.SETTLE_CYCLES(20)) tlx_crossbar_inst (.mclk_i(mclk), .rst_i(rst), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .front_panel_line_i(pin[2:0]), .front_panel_line_o(dout[2:0]),
        .front_panel_line_oe_o(doe[2:0]), .shared_trigger_line_i(pin[10:3]), .shared_trigger_line_o(dout[10:3]),
        .shared_trigger_line_oe_o(doe[10:3]), .star_trigger_line_i(pin[23:11]), .star_trigger_line_o(dout[23:11]),
        .star_trigger_line_oe_o(doe[23:11]), .backplane_ref_clock_i(refclk), .time_event_i(tev),
        .isolation_relay_close_o(relay), .timestamp_strobe_o(tss), .timestamp_rising_o(tsr));
    tlx_far_model tlx_far_model_inst (.mclk_i(mclk), .lvl_i(lvl), .dev_i(dout), .oe_i(doe), .pin_o(pin),
        .ref_o(refclk));
    initial begin
        mclk = 1'h0;
        forever #12.5 mclk = ~mclk;
    end
    // strobe lasts one cycle, so it is caught here
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (tss[2] === 1'h1) begin
            nstb <= nstb + 8'h01;
        end
        if (cyc == 20000) begin
            mismatches = mismatches + 1;
            finish_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input int n);
        @(posedge mclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        @(posedge mclk);
        while (pready !== 1'h1) @(posedge mclk);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        repeat (n) @(posedge mclk);
    endtask : apb
    task automatic t_route();
        apb(1'h0, 8'h2C, 32'h0, 0);
        chk(q, 32'h0000_001D);
        apb(1'h1, 8'h2C, 32'h0000_0103, 0);
        lvl[3] <= 1'h1;
        repeat (8) @(posedge mclk);
        chk({doe[11], dout[11]}, 32'h3);
        apb(1'h1, 8'h2C, 32'h0000_0503, 8);
        chk(dout[11], 32'h0);
        apb(1'h1, 8'h04, 32'h0000_0318, 0);
        tev[0] <= 1'h1;
        repeat (2) @(posedge mclk);
        chk(dout[1], 32'h1);
    endtask : t_route
    task automatic t_refuse();
        apb(1'h0, 8'h70, 32'h0, 0);
        chk(e, 32'h1);
        chk(q, 32'h0);
        apb(1'h1, 8'h64, 32'hFFFF_FFFF, 0);
        chk(e, 32'h1);
    endtask : t_refuse
    task automatic t_relay();
        chk(relay, 32'h0);
        apb(1'h1, 8'h68, 32'h1, 5);
        chk(relay, 32'h1);
        apb(1'h0, 8'h64, 32'h0, 30);
        chk(q[1:0], 32'h3);
        apb(1'h0, 8'h64, 32'h0, 0);
        chk(q[1:0], 32'h1);
        apb(1'h1, 8'h68, 32'h0, 20);
        chk(relay, 32'h1);
        repeat (50) @(posedge mclk);
        chk(relay, 32'h0);
        apb(1'h1, 8'h14, 32'h0000_0100, 5);
        chk(relay, 32'h1);
    endtask : t_relay
    task automatic t_stamp();
        apb(1'h1, 8'h60, 32'h0000_0030, 2);
        k = nstb;
        lvl[2] <= 1'h1;
        repeat (10) @(posedge mclk);
        chk(nstb - k, 32'h1);
        chk(tsr[2], 32'h1);
        lvl[2] <= 1'h0;
        repeat (10) @(posedge mclk);
        chk(nstb - k, 32'h2);
        chk(tsr[2], 32'h0);
    endtask : t_stamp
    task automatic t_sync();
        apb(1'h1, 8'h0C, 32'h0000_0304, 0);
        lvl[4] <= 1'h1;
        repeat (12) @(posedge mclk);
        chk({doe[3], dout[3]}, 32'h3);
    endtask : t_sync
    task automatic finish_test();
        if (mismatches == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test
    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata, lvl, tev} = {1'h1, 71'h0};
        repeat (10) @(posedge mclk);
        rst <= 1'h0;
        t_route();
        t_refuse();
        t_relay();
        t_stamp();
        t_sync();
        finish_test();
    end
endmodule : test_tlx_crossbar
